// ==== hw/low_power_clock_reset_control.sv ====
/*
 Low-power clock and reset control: power-down entry and recovery,
 idle and slow idle stalls, cycle clock output, master reset and boot
 start, with control and status registers on APB.
 Assumes pclk is the processor cycle clock (twice the input clock),
 presetn is the master reset, core-side inputs are on pclk and the
 power-down request and flag 2 pins are asynchronous.
*/
// Overview of operation
// [R01] Running-clock power-down exit after 200 input cycles
// [R02] Crystal-off power-down exit waits 4096 input cycles
// [R03] Power-down requested by pin or force bit
// [R04] Request raises nonmaskable edge-triggered interrupt
// [R05] Context bit selects resume or clean restart
// [R06] Reset ends power-down
// [R07] Acknowledge output shows power-down entered
// [R08] Idle stalls until unmasked interrupt, then continues
// [R09] DMA and autobuffer steals continue while idle
// [R10] Slow idle divides cycle clock by 16..128
// [R11] Serial, clock output, timer clocks divided alike
// [R12] Idle without divisor is plain idle
// [R13] Slow idle wakes within n cycles
// [R14] External party paces interrupts during slow idle
// [R15] Input clock steady except during power-down
// [R16] Cycle clock runs at twice input clock
// [R17] Cycle clock output gated by disable bit
// [R18] Board holds reset 2000 cycles at power-up
// [R19] Later resets need no clock stabilization
// [R20] Reset empties stacks, masks interrupts, clears mode status
// [R21] After reset boot, then fetch from 0x0000
// [R22] Memory mode sampled from flag 2 at reset
// [R23] Power-down interrupt vectors to 002C
// [R24] Interrupt servicing enabled after reset
// [R25] Request pin synchronized and edge detected
// [R26] Recovery counter on input clock, restarted per entry
`timescale 1ns/1ps
`include "lpcr_defines.svh"

module low_power_clock_reset_control #(
	parameter int RECOVER_RUNNING = `LPCR_RECOVER_RUNNING,
	parameter int RECOVER_OSC = `LPCR_RECOVER_OSC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic powerdown_request_pin_n,
	input wire logic flag_pin_2,
	input wire logic core_powerdown_enter,
	input wire lpcr_pkg::idle_req_s core_idle_req,
	input wire logic core_unmasked_interrupt,
	input wire logic core_bus_request,
	input wire logic core_boot_configured,
	input wire logic core_boot_done,
	output logic powerdown_ack,
	output logic powerdown_irq,
	output logic [13:0] powerdown_vector,
	output logic core_cycle_enable,
	output logic dma_steal_enable,
	output logic cycle_clock_output,
	output logic context_clear,
	output logic stack_clear,
	output logic fetch_start,
	output logic [13:0] fetch_address,
	output logic memory_mode,
	output logic global_int_enable,
	output logic [`LPCR_MODE_STATUS_W-1:0] mode_status_reg,
	output logic [`LPCR_INT_MASK_W-1:0] interrupt_mask_reg
);

	// Recovery counts cut to the counter width on purpose
	// Thirteen bits hold the oscillator wait with room to spare
	localparam logic [12:0] RECOVER_RUNNING_CNT = 13'(RECOVER_RUNNING);
	localparam logic [12:0] RECOVER_OSC_CNT = 13'(RECOVER_OSC);

	// Divisor value for an idle code
	// Shared by the sequencer load and kept in one place
	// so the four legal ratios cannot drift apart
	function automatic logic [7:0] div_value(input lpcr_pkg::idle_div_t code);
		logic [7:0] v;
		v = `LPCR_DIV16;
		case (code)
			2'h0: v = `LPCR_DIV16;
			2'h1: v = `LPCR_DIV32;
			2'h2: v = `LPCR_DIV64;
			default: v = `LPCR_DIV128;
		endcase
		return v;
	endfunction

	lpcr_pkg::state_e state_q;
	lpcr_pkg::ctrl_s ctrl_q;
	logic pd_sync1_q, pd_sync2_q, pd_prev_q;
	logic flag_sync1_q, flag_sync2_q;
	logic [1:0] strap_cnt_q;
	logic strap_done_q;
	logic in_tick_q;
	logic [12:0] recover_cnt_q;
	logic [7:0] div_q;
	logic [7:0] div_cnt_q;
	logic slow_tick;
	logic pd_edge, force_edge, force_prev_q;
	logic pd_level;
	logic recover_done;
	logic apb_access, apb_wr, apb_rd;

	// Request pin and strap pass two flops before any use
	// Both pins are board driven and may change at any time,
	// so only the second flop is read by the logic below
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_sync1_q <= 1'b0;
			pd_sync2_q <= 1'b0;
			flag_sync1_q <= 1'b0;
			flag_sync2_q <= 1'b0;
		end else begin
			pd_sync1_q <= ~powerdown_request_pin_n; // R25
			pd_sync2_q <= pd_sync1_q; // R25
			flag_sync1_q <= flag_pin_2;
			flag_sync2_q <= flag_sync1_q;
		end
	end

	// Edge detect on the synchronized pin and on the force bit
	// Previous values reset to the idle level, so no false edge
	// follows reset while the pin rests high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_prev_q <= 1'b0;
			force_prev_q <= 1'b0;
		end else begin
			pd_prev_q <= pd_sync2_q;
			force_prev_q <= ctrl_q.pd_force;
		end
	end

	assign pd_edge = pd_sync2_q & ~pd_prev_q; // R25
	assign force_edge = ctrl_q.pd_force & ~force_prev_q;
	assign pd_level = pd_sync2_q | ctrl_q.pd_force; // R03

	// Strap taken a few cycles after release, once the synchronizer holds it
	// Taken once only: the flag pin is free for other use afterwards
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_cnt_q <= 2'h0;
			strap_done_q <= 1'b0;
			memory_mode <= 1'b0;
		end else if (!strap_done_q) begin
			if (strap_cnt_q == `LPCR_STRAP_DELAY) begin
				memory_mode <= flag_sync2_q; // R22
				strap_done_q <= 1'b1;
			end else begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
			end
		end
	end

	// Input clock rate as an enable at half the cycle rate
	// One clock only; the input rate exists as this enable pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_tick_q <= 1'b0;
		end else begin
			in_tick_q <= ~in_tick_q; // R16
		end
	end

	// Slow idle divider; a plain cycle counter, not a clock
	// Restarts on every entry so the first tick lands n cycles in
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= 8'h00;
		end else if (state_q != lpcr_pkg::ST_SLOW || slow_tick) begin
			div_cnt_q <= 8'h00;
		end else begin
			div_cnt_q <= div_cnt_q + 8'h01; // R10
		end
	end

	assign slow_tick = (state_q == lpcr_pkg::ST_SLOW) && (div_cnt_q == div_q - 8'h01); // R10

	// Recovery counter in input cycles, cleared on every new entry
	// Held clear for the whole dormant span, so a short exit
	// never inherits counts from an earlier recovery
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recover_cnt_q <= 13'h0000;
		end else if (state_q == lpcr_pkg::ST_PD) begin
			recover_cnt_q <= 13'h0000; // R26
		end else if (state_q == lpcr_pkg::ST_RECOVER && in_tick_q) begin
			recover_cnt_q <= recover_cnt_q + 13'h0001; // R26
		end
	end

	// Crystal restart needs the long wait, a running clock the short one
	// Oscillator setting is read at exit, not latched at entry
	assign recover_done = in_tick_q && (recover_cnt_q == (ctrl_q.osc_off ?
		RECOVER_OSC_CNT - 13'h0001 : RECOVER_RUNNING_CNT - 13'h0001)); // R01 R02

	// Sequencer; reset aborts any state including power-down
	// Boot waits for the strap, a quiet bus and, if boot is configured, a finished load;
	// power-down is only entered on the core's own request,
	// which lets software run freely after the interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= lpcr_pkg::ST_BOOT; // R06 R19
			div_q <= `LPCR_DIV16;
		end else begin
			case (state_q)
				lpcr_pkg::ST_BOOT: begin
					if (strap_done_q && !core_bus_request &&
						(!core_boot_configured || core_boot_done)) begin
						state_q <= lpcr_pkg::ST_RUN; // R21
					end
				end
				lpcr_pkg::ST_RUN: begin
					if (core_powerdown_enter) begin
						state_q <= lpcr_pkg::ST_PD;
					end else if (core_idle_req.valid && core_idle_req.divided) begin
						div_q <= div_value(core_idle_req.div);
						state_q <= lpcr_pkg::ST_SLOW; // R10
					end else if (core_idle_req.valid) begin
						state_q <= lpcr_pkg::ST_IDLE; // R12
					end
				end
				lpcr_pkg::ST_IDLE: begin
					if (core_unmasked_interrupt) begin
						state_q <= lpcr_pkg::ST_RUN; // R08
					end
				end
				lpcr_pkg::ST_SLOW: begin
					// Wake only on a divided tick, so the wait never exceeds n
					if (core_unmasked_interrupt && slow_tick) begin
						state_q <= lpcr_pkg::ST_RUN; // R13
					end
				end
				lpcr_pkg::ST_PD: begin
					// Leave once the request is withdrawn
					if (!pd_level) begin
						state_q <= lpcr_pkg::ST_RECOVER;
					end
				end
				lpcr_pkg::ST_RECOVER: begin
					if (recover_done) begin
						state_q <= lpcr_pkg::ST_RUN; // R01 R02
					end
				end
				default: state_q <= lpcr_pkg::ST_BOOT;
			endcase
		end
	end

	// Power-down interrupt; not gated by the mask register
	// Only the global enable holds it back; a second request while
	// already dormant raises nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			powerdown_irq <= 1'b0;
			powerdown_vector <= `LPCR_PD_VECTOR;
		end else begin
			powerdown_irq <= (pd_edge | force_edge) & ctrl_q.gie &
				(state_q != lpcr_pkg::ST_PD); // R04 R03
			powerdown_vector <= `LPCR_PD_VECTOR; // R23
		end
	end

	// Acknowledge and core-facing strobes
	// Fetch strobe fires on the edge that leaves boot, while the
	// stack clear still stands for that one last cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			powerdown_ack <= 1'b0;
			context_clear <= 1'b0;
			fetch_start <= 1'b0;
			fetch_address <= `LPCR_BOOT_VECTOR;
			stack_clear <= 1'b1; // R20
		end else begin
			powerdown_ack <= (state_q == lpcr_pkg::ST_PD); // R07
			context_clear <= (state_q == lpcr_pkg::ST_RECOVER) && recover_done &&
				ctrl_q.ctx_clear; // R05
			fetch_start <= (state_q == lpcr_pkg::ST_BOOT) &&
				(lpcr_pkg::state_e'(lpcr_pkg::ST_BOOT) == state_q) && strap_done_q &&
				!core_bus_request && (!core_boot_configured || core_boot_done); // R21
			fetch_address <= `LPCR_BOOT_VECTOR; // R21
			stack_clear <= (state_q == lpcr_pkg::ST_BOOT); // R20
		end
	end

	// Cycle enables for core, timer and serial clocks, and the clock pin
	// The clock pin is a toggling flop, so it runs at half the cycle rate
	// (half the tick rate in slow idle) and stops low when disabled or dormant
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_cycle_enable <= 1'b0;
			dma_steal_enable <= 1'b0;
			cycle_clock_output <= 1'b0;
		end else begin
			core_cycle_enable <= (state_q == lpcr_pkg::ST_RUN) || slow_tick; // R11
			// Steals continue in both idle forms; stopped in boot, power-down and recovery
			dma_steal_enable <= (state_q == lpcr_pkg::ST_RUN) ||
				(state_q == lpcr_pkg::ST_IDLE) || (state_q == lpcr_pkg::ST_SLOW); // R09
			if (ctrl_q.clk_out_dis || state_q == lpcr_pkg::ST_PD) begin
				cycle_clock_output <= 1'b0; // R17
			end else if (state_q != lpcr_pkg::ST_SLOW || slow_tick) begin
				cycle_clock_output <= ~cycle_clock_output; // R11 R17
			end
		end
	end

	// Access phase decode
	// Reads are captured on entry to the access phase, writes commit
	// on the completing edge so a write is never half applied
	assign apb_access = psel & penable & ~pready;
	assign apb_wr = psel & penable & pready & pwrite;
	assign apb_rd = apb_access & ~pwrite;

	// Writable registers; master reset masks all and clears mode status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= lpcr_pkg::ctrl_s'(`LPCR_CTRL_RESET); // R24
			mode_status_reg <= `LPCR_MODE_STATUS_RESET; // R20
			interrupt_mask_reg <= `LPCR_INT_MASK_RESET; // R20
		end else if (apb_wr) begin
			if (paddr == `LPCR_CTRL_OFF) begin
				ctrl_q <= lpcr_pkg::ctrl_s'(pwdata[4:0]); // R03
			end else if (paddr == `LPCR_MODE_STATUS_OFF) begin
				mode_status_reg <= pwdata[`LPCR_MODE_STATUS_W-1:0];
			end else if (paddr == `LPCR_INT_MASK_OFF) begin
				interrupt_mask_reg <= pwdata[`LPCR_INT_MASK_W-1:0];
			end
		end
	end

	// Global enable output, one cycle behind the control bit
	// Reset value is on, as servicing starts enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_int_enable <= 1'b1; // R24
		end else begin
			global_int_enable <= ctrl_q.gie;
		end
	end

	// APB answer one cycle into the access phase; unmapped gives an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= apb_access;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (apb_access) begin
				if (paddr == `LPCR_CTRL_OFF) begin
					prdata <= apb_rd ? {27'h0, ctrl_q} : 32'h0000_0000;
				end else if (paddr == `LPCR_STATUS_OFF) begin
					prdata <= apb_rd ? {24'h0, memory_mode, powerdown_ack, state_q} :
						32'h0000_0000;
				end else if (paddr == `LPCR_MODE_STATUS_OFF) begin
					prdata <= apb_rd ? {25'h0, mode_status_reg} : 32'h0000_0000;
				end else if (paddr == `LPCR_INT_MASK_OFF) begin
					prdata <= apb_rd ? {22'h0, interrupt_mask_reg} : 32'h0000_0000;
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

endmodule // low_power_clock_reset_control

// ==== hw/lpcr_defines.svh ====
/*
 Offsets, field positions, reset values and timing counts for the
 low-power clock and reset control block.
 Assumes inclusion by its bare name from the package and the design.
*/
`ifndef LPCR_DEFINES_SVH
`define LPCR_DEFINES_SVH

// Register byte offsets on APB
`define LPCR_CTRL_OFF 12'h000
`define LPCR_STATUS_OFF 12'h004
`define LPCR_MODE_STATUS_OFF 12'h008
`define LPCR_INT_MASK_OFF 12'h00c

// Control register field positions
`define LPCR_CTRL_PD_FORCE 0
`define LPCR_CTRL_CTX_CLEAR 1
`define LPCR_CTRL_OSC_OFF 2
`define LPCR_CTRL_CLK_OUT_DIS 3
`define LPCR_CTRL_GIE 4

// Reset values: global interrupt servicing on, everything else off
`define LPCR_CTRL_RESET 5'h10
`define LPCR_MODE_STATUS_RESET 7'h00
`define LPCR_INT_MASK_RESET 10'h000
`define LPCR_MODE_STATUS_W 7
`define LPCR_INT_MASK_W 10

// Vectors
`define LPCR_PD_VECTOR 14'h002c
`define LPCR_BOOT_VECTOR 14'h0000

// Recovery times in input clock cycles
`define LPCR_RECOVER_RUNNING 200
`define LPCR_RECOVER_OSC 4096

// Slow idle divisors
`define LPCR_DIV16 8'h10
`define LPCR_DIV32 8'h20
`define LPCR_DIV64 8'h40
`define LPCR_DIV128 8'h80

// Cycles after reset release before the mode strap is taken
`define LPCR_STRAP_DELAY 2'h3

`endif

// ==== hw/lpcr_pkg.sv ====
/*
 Types shared by the low-power clock and reset control block.
 Assumes lpcr_defines.svh is on the include path.
*/
`include "lpcr_defines.svh"

package lpcr_pkg;

	// Sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_BOOT = 6'h01,
		ST_RUN = 6'h02,
		ST_IDLE = 6'h04,
		ST_SLOW = 6'h08,
		ST_PD = 6'h10,
		ST_RECOVER = 6'h20
	} state_e;

	// Idle divisor code as given with the idle instruction
	typedef logic [1:0] idle_div_t;

	// Software control bits
	typedef struct packed {
		logic gie;
		logic clk_out_dis;
		logic osc_off;
		logic ctx_clear;
		logic pd_force;
	} ctrl_s;

	// Core idle request
	typedef struct packed {
		logic valid;
		logic divided;
		idle_div_t div;
	} idle_req_s;

endpackage

// ==== verif/lpcr_board_model.sv ====
/*
 Board-side model: power-down request pin and the memory mode strap.
 Assumes the bench commands it on the rising edge of pclk.
*/
`timescale 1ns/1ps

module lpcr_board_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pd_req,
	input wire logic strap,
	output logic powerdown_request_pin_n = 1'b1,
	output logic flag_pin_2 = 1'b0
);
	int hold_q = 0;

	// Request pin follows the board command, active low
	always_ff @(posedge pclk) powerdown_request_pin_n <= !pd_req;

	// Strap held through reset and a little after; released pin wanders
	always_ff @(posedge pclk) begin
		hold_q <= presetn ? hold_q + 1 : 0;
		flag_pin_2 <= (hold_q < 8) ? strap : !flag_pin_2;
	end
endmodule // lpcr_board_model

// ==== verif/low_power_clock_reset_control_sva.sv ====
/*
 Port checker for the low-power clock and reset control block.
 Assumes binding to the top module, one clock, async active-low reset.
*/
`timescale 1ns/1ps

module lpcr_sva #(
	parameter int RECOVER_RUNNING = 200,
	parameter int RECOVER_OSC = 4096
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic powerdown_ack,
	input wire logic powerdown_irq,
	input wire logic [13:0] powerdown_vector,
	input wire logic core_powerdown_enter,
	input wire logic core_unmasked_interrupt,
	input wire logic core_cycle_enable,
	input wire logic dma_steal_enable,
	input wire logic cycle_clock_output,
	input wire logic stack_clear,
	input wire logic fetch_start,
	input wire logic [13:0] fetch_address,
	input wire logic global_int_enable
);
	logic [15:0] rec_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Cycles since leaving power-down, held until execution resumes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) rec_q <= 16'h0000;
		else if (powerdown_ack) rec_q <= 16'h0001;
		else if (rec_q != 16'h0000 && !core_cycle_enable) rec_q <= rec_q + 16'h0001;
		else rec_q <= 16'h0000;
	end

	apb_answer_a: assert property (psel && penable && !pready |=> pready
		&& pslverr == (paddr > 12'h00c) ##1 !pready) else $error("apb answer late or wrong");
	irq_pulse_a: assert property (powerdown_irq |=> !powerdown_irq)
		else $error("power-down interrupt not a pulse");
	irq_vector_a: assert property (powerdown_irq |-> powerdown_vector == 14'h002c
		&& global_int_enable) else $error("power-down vector wrong");
	ack_enter_a: assert property (core_powerdown_enter && core_cycle_enable
		&& $past(core_cycle_enable) |-> ##[1:3] powerdown_ack) else $error("no acknowledge");
	pd_quiet_a: assert property (powerdown_ack |-> !core_cycle_enable
		&& !dma_steal_enable && !cycle_clock_output) else $error("activity in power-down");
	recover_span_a: assert property ($rose(core_cycle_enable) && rec_q != 16'h0000
		|-> rec_q >= 2 * RECOVER_RUNNING - 2 && rec_q <= 2 * RECOVER_OSC + 4)
		else $error("recovery span wrong");
	boot_fetch_a: assert property ($fell(stack_clear) |-> $past(fetch_start)
		&& fetch_address == 14'h0000) else $error("boot fetch wrong");
	boot_hold_a: assert property (stack_clear |-> !core_cycle_enable
		&& !(fetch_start && $past(fetch_start))) else $error("running during reset boot");
	idle_wake_a: assert property (core_unmasked_interrupt && dma_steal_enable
		&& !core_cycle_enable |-> ##[1:140] core_cycle_enable) else $error("idle wake late");

	cover property (powerdown_irq);
	cover property ($rose(powerdown_ack));
	cover property (fetch_start);
endmodule // lpcr_sva

bind low_power_clock_reset_control lpcr_sva #(.RECOVER_RUNNING(RECOVER_RUNNING),
	.RECOVER_OSC(RECOVER_OSC)) chk_u (.*);

// ==== verif/low_power_clock_reset_control_tb.sv ====
/*
 Self-checking bench: APB register model, power-down, idle, boot.
 Assumes the design package and the board model are compiled first.
*/
`timescale 1ns/1ps

module low_power_clock_reset_control_tb;
	localparam int RR = 4;
	localparam int RX = 8;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, pd_req = 1'b0, strap = 1'b1, prev;
	logic powerdown_request_pin_n, flag_pin_2, core_powerdown_enter = 1'b0;
	lpcr_pkg::idle_req_s core_idle_req = '0;
	logic core_unmasked_interrupt = 1'b0, core_boot_done = 1'b0;
	logic core_bus_request = 1'b1, core_boot_configured = 1'b1;
	logic powerdown_ack, powerdown_irq, core_cycle_enable, dma_steal_enable;
	logic cycle_clock_output, context_clear, stack_clear, fetch_start;
	logic memory_mode, global_int_enable;
	logic [13:0] powerdown_vector, fetch_address;
	logic [6:0] mode_status_reg;
	logic [9:0] interrupt_mask_reg;
	int num_errors = 0, cmp_count = 0, irq_seen = 0, ctx_seen = 0, rec = 0, n, i;
	int regs[4], msk[4] = '{32'h1f, 0, 32'h7f, 32'h3ff};

	low_power_clock_reset_control #(.RECOVER_RUNNING(RR), .RECOVER_OSC(RX)) dut_u (.pclk,
		.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.powerdown_request_pin_n, .flag_pin_2, .core_powerdown_enter, .core_idle_req,
		.core_unmasked_interrupt, .core_bus_request, .core_boot_configured,
		.core_boot_done, .powerdown_ack, .powerdown_irq, .powerdown_vector,
		.core_cycle_enable, .dma_steal_enable, .cycle_clock_output, .context_clear,
		.stack_clear, .fetch_start, .fetch_address, .memory_mode, .global_int_enable,
		.mode_status_reg, .interrupt_mask_reg);
	lpcr_board_model board_u (.pclk, .presetn, .pd_req, .strap,
		.powerdown_request_pin_n, .flag_pin_2);

	// Clock and hang guard
	initial forever #20 pclk = ~pclk;
	initial begin
		#(40 * 20000);
		num_errors++;
		conclude();
	end

	// Event counters and recovery stopwatch
	always @(posedge pclk) begin
		prev <= core_cycle_enable;
		rec <= (powerdown_ack === 1'b1) ? 0 : rec + 1;
		if (powerdown_irq === 1'b1) irq_seen++;
		if (context_clear === 1'b1) ctx_seen++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (w && a <= 12'h00c) regs[a[3:2]] = d & msk[a[3:2]];
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk(er, a > 12'h00c);
	endtask

	task automatic do_reset(input logic s);
		strap <= s;
		presetn <= 1'b0;
		core_boot_done <= 1'b0;
		core_bus_request <= 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		chk(stack_clear, 1'b1);
		core_boot_done <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(stack_clear, 1'b1);
		core_bus_request <= 1'b0;
		for (n = 0; n < 20 && fetch_start !== 1'b1; n++) @(posedge pclk);
		chk(fetch_address, 32'h0);
		chk(memory_mode, s);
		chk(global_int_enable, 1'b1);
		chk(powerdown_ack, 1'b0);
		regs = '{32'h10, 0, 0, 0};
	endtask

	task conclude;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial begin
		void'($urandom(32'ha440));
		do_reset(1'b1);
		for (i = 0; i < 4; i += 2) rd_chk(i * 4, regs[i]);
		rd_chk(12'h00c, regs[3]);
		rd_chk(12'h004, {strap, 7'h02});
		rd_chk(12'h010, 32'h0);
		repeat (4) for (i = 2; i < 4; i++) begin
			apb(1'b1, i * 4, $urandom);
			rd_chk(i * 4, regs[i]);
		end
		chk(mode_status_reg, regs[2]);
		chk(interrupt_mask_reg, regs[3]);
		apb(1'b1, 12'h000, 32'h18);
		@(posedge pclk);
		repeat (8) begin
			@(posedge pclk);
			chk(cycle_clock_output, 1'b0);
		end
		apb(1'b1, 12'h000, 32'h10);
		@(posedge pclk);
		n = cycle_clock_output;
		@(posedge pclk);
		chk(cycle_clock_output, !n);
		// Pin request with running clock, then forced request with crystal off
		for (i = 0; i < 2; i++) begin
			irq_seen = 0;
			ctx_seen = 0;
			if (i == 0) pd_req <= 1'b1;
			else apb(1'b1, 12'h000, 32'h17);
			repeat (8) @(posedge pclk);
			chk(irq_seen, 1);
			core_powerdown_enter <= 1'b1;
			@(posedge pclk);
			core_powerdown_enter <= 1'b0;
			rd_chk(12'h004, {strap, 7'h50});
			if (i == 0) pd_req <= 1'b0;
			else apb(1'b1, 12'h000, 32'h16);
			for (n = 0; n < 60 && core_cycle_enable !== 1'b1; n++) @(posedge pclk);
			chk(rec >= 2 * (i ? RX : RR) - 2 && rec <= 2 * (i ? RX : RR) + 4, 1);
			@(posedge pclk);
			chk(ctx_seen, i);
		end
		// Slow idle for each divisor, then plain idle
		for (i = 0; i < 5; i++) begin
			@(posedge pclk);
			core_idle_req <= {1'b1, i < 4, 2'(i)};
			@(posedge pclk);
			core_idle_req <= '0;
			repeat (3) @(posedge pclk);
			chk(dma_steal_enable, 1'b1);
			if (i < 4) begin
				for (n = 0; n < 300 && core_cycle_enable !== 1'b1; n++) @(posedge pclk);
				@(posedge pclk);
				for (n = 1; n < 300 && core_cycle_enable !== 1'b1; n++) @(posedge pclk);
				chk(n, 16 << i);
			end else chk(core_cycle_enable, 1'b0);
			core_unmasked_interrupt <= 1'b1;
			for (n = 0; n < 300 && !(core_cycle_enable === 1'b1 && prev === 1'b1); n++)
				@(posedge pclk);
			core_unmasked_interrupt <= 1'b0;
			chk(n <= (i < 4 ? 16 << i : 1) + 5, 1);
		end
		// Servicing off, enter power-down, then reset ends it
		apb(1'b1, 12'h000, 32'h00);
		irq_seen = 0;
		pd_req <= 1'b1;
		repeat (8) @(posedge pclk);
		chk(irq_seen, 0);
		core_powerdown_enter <= 1'b1;
		@(posedge pclk);
		core_powerdown_enter <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(powerdown_ack, 1'b1);
		pd_req <= 1'b0;
		do_reset(1'b0);
		rd_chk(12'h000, 32'h10);
		conclude();
	end
endmodule // low_power_clock_reset_control_tb
